//--- hw/bus_strobe_pkg.sv
package bus_strobe_pkg;
	// cycle-type codes on the three active-low code lines
	typedef enum logic [2:0] {
		CYC_INTA = 3'h0,
		CYC_IO_RD = 3'h1,
		CYC_IO_WR = 3'h2,
		CYC_HALT = 3'h3,
		CYC_FETCH = 3'h4,
		CYC_MEM_RD = 3'h5,
		CYC_MEM_WR = 3'h6,
		CYC_IDLE = 3'h7
	} cycle_kind_type;
	// bus sequencer states, gray coded along idle-addr-data-done
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ADDR = 2'h1,
		ST_DATA = 2'h3,
		ST_DONE = 2'h2
	} bus_state_type;
	localparam logic [19:0] UCS_BASE_RESET = 20'hFFC00;
	localparam logic [19:0] UCS_LIMIT_RESET = 20'hFFFFF;
endpackage

//--- hw/bus_cycle_status_strobes.sv
// Behaviour
// - reset indication high while reset, and while reset request input is low.
// - codes 000..011 mean interrupt acknowledge, read I/O, write I/O, halt.
// - codes 100 fetch, 101 memory read, 110 memory write, 111 idle.
// - write strobe low marks valid write data for the addressed device.
// - upper chip select low for memory cycles inside the programmed range.
// - suspend instruction stalls while test input high, resumes when sampled low.
// - read strobe low asks the addressed device to drive data.
// - cycle ends on ready high, unless internal chip select handles it or the cycle is a halt.
// - reset request aborts any cycle at once, outputs go to known states.
`timescale 1ns/1ns
module bus_cycle_status_strobes
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic reset_req_n,
	input wire logic ready,
	input wire logic test_n,
	input wire logic cyc_start,
	input wire logic [2:0] cyc_kind,
	input wire logic [19:0] cyc_addr,
	input wire logic [19:0] ucs_base,
	input wire logic [19:0] ucs_limit,
	input wire logic ucs_ignore_ready,
	input wire logic suspend_exec,
	output logic cyc_busy,
	output logic cyc_done,
	output logic suspend_stall,
	output logic reset_ind,
	output logic cycle_code_bit0_n,
	output logic cycle_code_bit1_n,
	output logic cycle_code_bit2_n,
	output logic rd_strobe_n,
	output logic wr_strobe_n,
	output logic ucs_sel_n
);
	bus_strobe_pkg::bus_state_type state, next_state;
	logic [2:0] code, next_code;
	logic rd_n, next_rd_n;
	logic wr_n, next_wr_n;
	logic ucs_n, next_ucs_n;
	logic in_rst, next_in_rst;
	wire logic rst_any = sys_rst | ~reset_req_n;

	function automatic logic is_mem(input logic [2:0] k);
	begin
		is_mem = k[2] && (k != bus_strobe_pkg::CYC_IDLE);
	end
	endfunction

	function automatic logic is_write(input logic [2:0] k);
	begin
		is_write = (k == bus_strobe_pkg::CYC_MEM_WR) || (k == bus_strobe_pkg::CYC_IO_WR);
	end
	endfunction

	function automatic logic is_read(input logic [2:0] k);
	begin
		is_read = (k == bus_strobe_pkg::CYC_MEM_RD) || (k == bus_strobe_pkg::CYC_IO_RD)
			|| (k == bus_strobe_pkg::CYC_FETCH) || (k == bus_strobe_pkg::CYC_INTA);
	end
	endfunction

	always_comb
	begin
		next_state = state;
		next_code = code;
		next_rd_n = rd_n;
		next_wr_n = wr_n;
		next_ucs_n = ucs_n;
		next_in_rst = 1'b0;
		case (state)
			bus_strobe_pkg::ST_IDLE:
			begin
				next_code = bus_strobe_pkg::CYC_IDLE;
				next_rd_n = 1'b1;
				next_wr_n = 1'b1;
				next_ucs_n = 1'b1;
				if (cyc_start && cyc_kind != bus_strobe_pkg::CYC_IDLE)
				begin
					next_state = bus_strobe_pkg::ST_ADDR;
					next_code = cyc_kind;
					// chip select decoded once at address time, held to cycle end
					next_ucs_n = ~(is_mem(cyc_kind) && cyc_addr >= ucs_base && cyc_addr <= ucs_limit);
				end
			end
			bus_strobe_pkg::ST_ADDR:
			begin
				next_state = bus_strobe_pkg::ST_DATA;
				next_rd_n = ~is_read(code);
				next_wr_n = ~is_write(code);
			end
			bus_strobe_pkg::ST_DATA:
			begin
				// internal select terminates without waiting on ready
				if (ready || (!ucs_n && ucs_ignore_ready) || code == bus_strobe_pkg::CYC_HALT)
				begin
					next_state = bus_strobe_pkg::ST_DONE;
					next_rd_n = 1'b1;
					next_wr_n = 1'b1;
				end
			end
			bus_strobe_pkg::ST_DONE:
			begin
				next_state = bus_strobe_pkg::ST_IDLE;
				next_code = bus_strobe_pkg::CYC_IDLE;
				next_ucs_n = 1'b1;
			end
			default:
			begin
				next_state = bus_strobe_pkg::ST_IDLE;
			end
		endcase
	end

	// reset request acts asynchronously so an open cycle is cut at once
	always_ff @(posedge core_clk or posedge rst_any)
	begin
		if (rst_any)
		begin
			state <= bus_strobe_pkg::ST_IDLE;
			code <= bus_strobe_pkg::CYC_IDLE;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			ucs_n <= 1'b1;
			in_rst <= 1'b1;
		end
		else
		begin
			state <= next_state;
			code <= next_code;
			rd_n <= next_rd_n;
			wr_n <= next_wr_n;
			ucs_n <= next_ucs_n;
			in_rst <= next_in_rst;
		end
	end

	assign reset_ind = in_rst;
	assign {cycle_code_bit2_n, cycle_code_bit1_n, cycle_code_bit0_n} = code;
	assign rd_strobe_n = rd_n;
	assign wr_strobe_n = wr_n;
	assign ucs_sel_n = ucs_n;
	assign cyc_busy = (state != bus_strobe_pkg::ST_IDLE);
	assign cyc_done = (state == bus_strobe_pkg::ST_DONE);
	// test input taken as synchronous; stall is combinational so resume costs no cycle
	assign suspend_stall = suspend_exec && test_n;

	rst_ind_a: assert property (@(posedge core_clk) !reset_req_n |-> reset_ind)
		else $error("reset indication low during reset request");

	idle_quiet_a: assert property (@(posedge core_clk) disable iff (rst_any)
		state == bus_strobe_pkg::ST_IDLE |-> code == 3'h7 && rd_strobe_n && wr_strobe_n && ucs_sel_n)
		else $error("idle bus not quiet");

	code_load_a: assert property (@(posedge core_clk) disable iff (rst_any)
		state == bus_strobe_pkg::ST_IDLE && cyc_start && cyc_kind != 3'h7 |=> code == $past(cyc_kind))
		else $error("cycle code not driven");

	fetch_code_a: assert property (@(posedge core_clk) disable iff (rst_any)
		state == bus_strobe_pkg::ST_IDLE && cyc_start && cyc_kind == 3'h4
		|=> {cycle_code_bit2_n, cycle_code_bit1_n, cycle_code_bit0_n} == 3'h4)
		else $error("fetch code wrong");

	wr_strobe_a: assert property (@(posedge core_clk) disable iff (rst_any)
		!wr_strobe_n |-> code == 3'h6 || code == 3'h2)
		else $error("write strobe outside write cycle");

	rd_strobe_a: assert property (@(posedge core_clk) disable iff (rst_any)
		state == bus_strobe_pkg::ST_ADDR && (code == 3'h5 || code == 3'h1) |=> !rd_strobe_n)
		else $error("read strobe missing");

	ucs_range_a: assert property (@(posedge core_clk) disable iff (rst_any)
		state == bus_strobe_pkg::ST_IDLE && cyc_start && cyc_kind == 3'h5
		&& cyc_addr >= ucs_base && cyc_addr <= ucs_limit |=> !ucs_sel_n)
		else $error("upper select not asserted in range");

	ready_wait_a: assert property (@(posedge core_clk) disable iff (rst_any)
		state == bus_strobe_pkg::ST_DATA && !ready && !(!ucs_n && ucs_ignore_ready)
		&& code != 3'h3 |=> state == bus_strobe_pkg::ST_DATA)
		else $error("cycle ended without ready");

	stall_a: assert property (@(posedge core_clk) suspend_exec && test_n |-> suspend_stall)
		else $error("suspend did not stall");

	abort_a: assert property (@(posedge core_clk) $fell(reset_req_n) |=> state == bus_strobe_pkg::ST_IDLE
		&& rd_strobe_n && wr_strobe_n)
		else $error("cycle not aborted");

	rst_release_a: assert property (@(posedge core_clk) disable iff (rst_any)
		reset_ind |=> !reset_ind)
		else $error("reset indication held after release");

	done_pulse_a: assert property (@(posedge core_clk) disable iff (rst_any)
		cyc_done |=> !cyc_done && state == bus_strobe_pkg::ST_IDLE)
		else $error("done not a single pulse");

	// a start while busy is dropped, not queued
	busy_refuse_a: assert property (@(posedge core_clk) disable iff (rst_any)
		state == bus_strobe_pkg::ST_DATA && cyc_start |=> state != bus_strobe_pkg::ST_ADDR)
		else $error("start taken while busy");

	halt_end_a: assert property (@(posedge core_clk) disable iff (rst_any)
		state == bus_strobe_pkg::ST_DATA && code == 3'h3 |=> state == bus_strobe_pkg::ST_DONE)
		else $error("halt cycle waited");

	ucs_miss_a: assert property (@(posedge core_clk) disable iff (rst_any)
		state == bus_strobe_pkg::ST_IDLE && cyc_start && cyc_kind inside {3'h4, 3'h5, 3'h6}
		&& (cyc_addr < ucs_base || cyc_addr > ucs_limit) |=> ucs_sel_n)
		else $error("upper select asserted out of range");

	ucs_hold_a: assert property (@(posedge core_clk) disable iff (rst_any)
		state == bus_strobe_pkg::ST_DATA |=> $stable(ucs_sel_n))
		else $error("upper select moved mid cycle");

	// covers for the main scenarios
	mem_rd_c: cover property (@(posedge core_clk) disable iff (rst_any) !rd_strobe_n && !ucs_sel_n);
	wait_c: cover property (@(posedge core_clk) disable iff (rst_any) state == bus_strobe_pkg::ST_DATA && !ready);
	io_wr_c: cover property (@(posedge core_clk) disable iff (rst_any) !wr_strobe_n && code == 3'h2);
	halt_c: cover property (@(posedge core_clk) disable iff (rst_any) state == bus_strobe_pkg::ST_DATA && code == 3'h3);
	ucs_skip_c: cover property (@(posedge core_clk) disable iff (rst_any) cyc_done && !ucs_sel_n && ucs_ignore_ready);
endmodule // bus_cycle_status_strobes

//--- verif/mem_io_partner.sv
`timescale 1ns/1ns
module mem_io_partner
(
	input wire logic core_clk,
	input wire logic rd_strobe_n,
	input wire logic wr_strobe_n,
	input wire logic [3:0] wait_cycles,
	output logic ready
);
	logic [3:0] cnt;
	// ready only after a set wait, so slow devices get exercised too
	always_ff @(posedge core_clk)
	begin
		cnt <= (rd_strobe_n & wr_strobe_n) ? 4'h0 : cnt + 4'h1;
		ready <= !(rd_strobe_n & wr_strobe_n) && cnt >= wait_cycles;
	end
endmodule // mem_io_partner

//--- verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic core_clk, sys_rst, reset_req_n, ready, test_n, cyc_start, ucs_ignore_ready, suspend_exec;
	logic [2:0] cyc_kind;
	logic [19:0] cyc_addr;
	logic [19:0] ucs_base, ucs_limit;
	logic [3:0] wait_cycles;
	logic cyc_busy, cyc_done, suspend_stall, reset_ind, rd_strobe_n, wr_strobe_n, ucs_sel_n;
	logic cycle_code_bit0_n, cycle_code_bit1_n, cycle_code_bit2_n;
	int n_errors, num_checks;
	bus_cycle_status_strobes i_bus_cycle_status_strobes(.core_clk, .sys_rst, .reset_req_n, .ready, .test_n,
		.cyc_start, .cyc_kind, .cyc_addr, .ucs_base,
		.ucs_limit, .ucs_ignore_ready, .suspend_exec, .cyc_busy, .cyc_done,
		.suspend_stall, .reset_ind, .cycle_code_bit0_n, .cycle_code_bit1_n, .cycle_code_bit2_n, .rd_strobe_n,
		.wr_strobe_n, .ucs_sel_n);
	mem_io_partner i_mem_io_partner(.core_clk, .rd_strobe_n, .wr_strobe_n, .wait_cycles, .ready);
	task chk(string nm, logic [2:0] seen, logic [2:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task finish_test();
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task run(logic [2:0] k, logic [19:0] a, int lim);
		cyc_start = 1'b1;
		cyc_kind = k;
		cyc_addr = a;
		@(negedge core_clk);
		cyc_start = 1'b0;
		chk("code", {cycle_code_bit2_n, cycle_code_bit1_n, cycle_code_bit0_n}, k);
		chk("ucs", ucs_sel_n, !(k inside {4, 5, 6} && a >= ucs_base && a <= ucs_limit));
		chk("busy", cyc_busy, 3'h1);
		@(negedge core_clk);
		chk("rd", rd_strobe_n, !(k inside {0, 1, 4, 5}));
		chk("wr", wr_strobe_n, !(k inside {2, 6}));
		for (int i = 0; i < lim && cyc_done !== 1'b1; i++)
			@(negedge core_clk);
		chk("done", cyc_done, 3'h1);
		if (cyc_done !== 1'b1)
			finish_test();
		@(negedge core_clk);
		chk("idle", {cycle_code_bit2_n, cycle_code_bit1_n, cycle_code_bit0_n}, 3'h7);
		chk("idle sel", {ucs_sel_n, rd_strobe_n, wr_strobe_n}, 3'h7);
		chk("idle busy", {cyc_busy, cyc_done}, 3'h0);
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = !core_clk;
	end
	initial
	begin
		sys_rst = 1'b1;
		reset_req_n = 1'b1;
		test_n = 1'b1;
		cyc_start = 1'b0;
		cyc_kind = 3'h7;
		cyc_addr = 20'h00000;
		ucs_base = bus_strobe_pkg::UCS_BASE_RESET;
		ucs_limit = bus_strobe_pkg::UCS_LIMIT_RESET;
		ucs_ignore_ready = 1'b0;
		suspend_exec = 1'b0;
		wait_cycles = 4'h0;
		repeat (10) @(negedge core_clk);
		chk("rst", {reset_ind, rd_strobe_n, ucs_sel_n}, 3'h7);
		sys_rst = 1'b0;
		@(negedge core_clk);
		chk("rst out", reset_ind, 3'h0);
		for (int k = 0; k < 7; k++)
			run(k[2:0], 20'hFFC00, 20);
		ucs_ignore_ready = 1'b1;
		wait_cycles = 4'hF;
		run(3'h5, 20'hFFFFF, 3);
		run(3'h6, 20'hFFBFF, 30);
		ucs_base = 20'h80000;
		ucs_limit = 20'h8FFFF;
		run(3'h5, 20'h90000, 30);
		run(3'h4, 20'h80000, 30);
		suspend_exec = 1'b1;
		@(negedge core_clk);
		chk("stall", suspend_stall, 3'h1);
		test_n = 1'b0;
		@(negedge core_clk);
		chk("stall", suspend_stall, 3'h0);
		cyc_start = 1'b1;
		cyc_kind = 3'h1;
		@(negedge core_clk);
		cyc_start = 1'b0;
		repeat (2) @(negedge core_clk);
		reset_req_n = 1'b0;
		#1;
		chk("abort", {reset_ind, rd_strobe_n, cycle_code_bit1_n}, 3'h7);
		@(negedge core_clk);
		chk("abort hold", {reset_ind, wr_strobe_n, cyc_busy}, 3'h6);
		reset_req_n = 1'b1;
		@(negedge core_clk);
		chk("rst out", reset_ind, 3'h0);
		run(3'h2, 20'h00000, 30);
		finish_test();
	end
endmodule // tb_top
